// file: src/ior_pkg.sv
package ior_pkg;

    // Window geometry
    localparam int          IOR_ADDR_W   = 5;
    localparam int          IOR_DATA_W   = 8;
    localparam int          IOR_PORTS    = 4;

    // Register offsets
    localparam logic [4:0]  OFF_FIRST_PORT_DATA       = 5'h00;
    localparam logic [4:0]  OFF_SECOND_PORT_DATA      = 5'h01;
    localparam logic [4:0]  OFF_THIRD_PORT_DATA       = 5'h02;
    localparam logic [4:0]  OFF_FOURTH_PORT_DATA      = 5'h03;
    localparam logic [4:0]  OFF_FIRST_PORT_DIRECTION  = 5'h04;
    localparam logic [4:0]  OFF_SECOND_PORT_DIRECTION = 5'h05;
    localparam logic [4:0]  OFF_THIRD_PORT_DIRECTION  = 5'h06;
    localparam logic [4:0]  OFF_FOURTH_PORT_DIRECTION = 5'h07;
    localparam logic [4:0]  OFF_UNUSED_LOW_FIRST      = 5'h08;
    localparam logic [4:0]  OFF_UNUSED_LOW_LAST       = 5'h11;
    localparam logic [4:0]  OFF_TIMER_CONTROL         = 5'h12;
    localparam logic [4:0]  OFF_TIMER_STATUS          = 5'h13;
    localparam logic [4:0]  OFF_CAPTURE_VALUE_HIGH    = 5'h14;
    localparam logic [4:0]  OFF_CAPTURE_VALUE_LOW     = 5'h15;
    localparam logic [4:0]  OFF_COMPARE_VALUE_HIGH    = 5'h16;
    localparam logic [4:0]  OFF_COMPARE_VALUE_LOW     = 5'h17;
    localparam logic [4:0]  OFF_COUNTER_VALUE_HIGH    = 5'h18;
    localparam logic [4:0]  OFF_COUNTER_VALUE_LOW     = 5'h19;
    localparam logic [4:0]  OFF_ALTERNATE_COUNTER_HIGH = 5'h1A;
    localparam logic [4:0]  OFF_ALTERNATE_COUNTER_LOW = 5'h1B;
    localparam logic [4:0]  OFF_UNUSED_HIGH_FIRST     = 5'h1C;
    localparam logic [4:0]  OFF_UNUSED_HIGH_LAST      = 5'h1E;
    localparam logic [4:0]  OFF_RESERVED              = 5'h1F;

    // Per-port bit layout, index 0 is the first port
    typedef logic [7:0] ior_mask_t [IOR_PORTS];
    localparam ior_mask_t   PORT_BIDIR_MASK    = '{8'hFF, 8'hE0, 8'hFF, 8'h20};
    localparam ior_mask_t   PORT_INPUT_MASK    = '{8'h00, 8'h00, 8'h00, 8'h80};
    localparam ior_mask_t   PORT_DATA_ONE_MASK = '{8'h00, 8'h00, 8'h00, 8'h10};
    localparam ior_mask_t   PORT_DIR_ONE_MASK  = '{8'h00, 8'h1F, 8'h00, 8'h00};

    // Timer control field positions
    localparam int          TCTL_CAPTURE_IRQ_ENABLE  = 7;
    localparam int          TCTL_COMPARE_IRQ_ENABLE  = 6;
    localparam int          TCTL_OVERFLOW_IRQ_ENABLE = 5;
    localparam int          TCTL_CAPTURE_EDGE_SELECT = 1;
    localparam int          TCTL_COMPARE_OUTPUT_LEVEL = 0;
    localparam logic [7:0]  TCTL_WRITE_MASK          = 8'hE3;

    // Timer status field positions
    localparam int          TSTS_CAPTURE_FLAG  = 7;
    localparam int          TSTS_COMPARE_FLAG  = 6;
    localparam int          TSTS_OVERFLOW_FLAG = 5;

    // Values after reset, and the read value of unmapped offsets
    localparam logic [7:0]  RST_PORT_DATA      = 8'h00;
    localparam logic [7:0]  RST_PORT_DIRECTION = 8'h00;
    localparam logic [7:0]  RST_TIMER_CONTROL  = 8'h00;
    localparam logic [2:0]  RST_TIMER_FLAGS    = 3'h0;
    localparam logic [7:0]  RD_UNMAPPED        = 8'h00;

endpackage : ior_pkg

// file: src/ior_port_if.sv
`timescale 1ns/1ps
`default_nettype none

interface ior_port_if #(
    parameter int W = 8
);
    logic [W-1:0] wdata;
    logic         data_we;
    logic         dir_we;
    logic [W-1:0] pin_in;
    logic [W-1:0] data_rd;
    logic [W-1:0] dir_rd;
    logic [W-1:0] pin_out;
    logic [W-1:0] pin_oe;

    modport ctl (
        output wdata,
        output data_we,
        output dir_we,
        output pin_in,
        input  data_rd,
        input  dir_rd,
        input  pin_out,
        input  pin_oe
    );

    modport port (
        input  wdata,
        input  data_we,
        input  dir_we,
        input  pin_in,
        output data_rd,
        output dir_rd,
        output pin_out,
        output pin_oe
    );
endinterface : ior_port_if

`default_nettype wire

// file: src/ior_port.sv
`timescale 1ns/1ps
`default_nettype none

module ior_port #(
    parameter int           W            = 8,
    parameter logic [W-1:0] BIDIR_MASK   = '1,
    parameter logic [W-1:0] INPUT_MASK   = '0,
    parameter logic [W-1:0] DATA_ONE_MASK = '0,
    parameter logic [W-1:0] DIR_ONE_MASK = '0
) (
    // System
    input  wire logic clk,
    input  wire logic rst,
    // Register side and pins
    ior_port_if.port  bus
);
    logic [W-1:0] data_q;
    logic [W-1:0] dir_q;
    logic [W-1:0] next_data;
    logic [W-1:0] next_dir;

    if ((BIDIR_MASK & INPUT_MASK) != '0 || (DIR_ONE_MASK & BIDIR_MASK) != '0) begin : g_chk
        $error("ior_port: overlapping bit masks");
    end

    always_comb begin
        next_data = data_q;
        next_dir  = dir_q;
        // Latch is written even for input pins so it is ready when turned to output
        if (bus.data_we) begin
            next_data = bus.wdata & BIDIR_MASK;
        end
        if (bus.dir_we) begin
            next_dir = bus.wdata & BIDIR_MASK;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            data_q <= ior_pkg::RST_PORT_DATA[W-1:0];
            dir_q  <= ior_pkg::RST_PORT_DIRECTION[W-1:0];
        end else begin
            data_q <= next_data;
            dir_q  <= next_dir;
        end
    end

    assign bus.pin_out = data_q & dir_q;
    assign bus.pin_oe  = dir_q & BIDIR_MASK;
    // Output bits read the latch, input bits the pin, missing bits a constant
    assign bus.data_rd = (BIDIR_MASK & dir_q & data_q)
                       | (BIDIR_MASK & ~dir_q & bus.pin_in)
                       | (INPUT_MASK & bus.pin_in)
                       | DATA_ONE_MASK;
    assign bus.dir_rd  = (dir_q & BIDIR_MASK) | DIR_ONE_MASK;

endmodule : ior_port

`default_nettype wire

// file: src/ior_io_regs.sv
`timescale 1ns/1ps
`default_nettype none

module ior_io_regs #(
    parameter int W = ior_pkg::IOR_DATA_W
) (
    // System
    input  wire logic                        clk,
    input  wire logic                        rst,
    // Internal memory bus
    input  wire logic                        bus_sel,
    input  wire logic                        bus_rd,
    input  wire logic                        bus_wr,
    input  wire logic [4:0]                  bus_addr,
    input  wire logic [W-1:0]                bus_wdata,
    output logic      [W-1:0]                bus_rdata,
    output logic                             bus_rvalid,
    // Port pins, index 0 is the first port
    input  wire logic [3:0][W-1:0]           port_pin_in,
    output logic      [3:0][W-1:0]           port_pin_out,
    output logic      [3:0][W-1:0]           port_pin_oe,
    // Timer core values and events
    input  wire logic [15:0]                 counter_value,
    input  wire logic [15:0]                 capture_value,
    input  wire logic                        capture_event,
    input  wire logic                        compare_event,
    input  wire logic                        overflow_event,
    // Timer controls
    output logic                             capture_irq_enable,
    output logic                             compare_irq_enable,
    output logic                             overflow_irq_enable,
    output logic                             capture_edge_select,
    output logic                             compare_output_level,
    output logic      [15:0]                 compare_value,
    output logic                             capture_inhibit,
    output logic                             timer_irq_request,
    output logic                             capture_input_pin
);
    localparam int NP = ior_pkg::IOR_PORTS;

    if (W != 8) begin : g_chk
        $error("ior_io_regs: data width must be 8");
    end

    // Access strobes; under reset nothing is taken
    logic rd_take;
    logic wr_take;
    assign rd_take = bus_sel & bus_rd;
    assign wr_take = bus_sel & bus_wr;

    // Ports
    ior_port_if #(.W(W)) pif [NP] ();
    logic [NP-1:0][W-1:0] port_data_rd;
    logic [NP-1:0][W-1:0] port_dir_rd;

    for (genvar i = 0; i < NP; i++) begin : g_port
        assign pif[i].wdata   = bus_wdata;
        assign pif[i].data_we = wr_take && (bus_addr == 5'(i));
        assign pif[i].dir_we  = wr_take && (bus_addr == 5'(i + NP));
        assign pif[i].pin_in  = port_pin_in[i];
        assign port_data_rd[i] = pif[i].data_rd;
        assign port_dir_rd[i]  = pif[i].dir_rd;
        assign port_pin_out[i] = pif[i].pin_out;
        assign port_pin_oe[i]  = pif[i].pin_oe;

        ior_port #(
            .W            (W),
            .BIDIR_MASK   (ior_pkg::PORT_BIDIR_MASK[i]),
            .INPUT_MASK   (ior_pkg::PORT_INPUT_MASK[i]),
            .DATA_ONE_MASK(ior_pkg::PORT_DATA_ONE_MASK[i]),
            .DIR_ONE_MASK (ior_pkg::PORT_DIR_ONE_MASK[i])
        ) u_port (
            .clk(clk),
            .rst(rst),
            .bus(pif[i])
        );
    end

    // Shared pin: fourth port bit 7 is also the capture input
    assign capture_input_pin = port_pin_in[3][7];

    // Timer register group
    logic [W-1:0] tctl;
    logic [2:0]   flags;
    logic [2:0]   armed;
    logic [W-1:0] cnt_buf;
    logic         cnt_latched;
    logic         cap_hold;
    logic [W-1:0] next_tctl;
    logic [2:0]   next_flags;
    logic [2:0]   next_armed;
    logic [W-1:0] next_cnt_buf;
    logic         next_cnt_latched;
    logic         next_cap_hold;

    // Flag vector index: 2 capture, 1 compare, 0 overflow
    logic [2:0] flag_event;
    logic [2:0] flag_clear;
    assign flag_event = {capture_event, compare_event, overflow_event};

    always_comb begin
        flag_clear[0] = rd_take && (bus_addr == ior_pkg::OFF_COUNTER_VALUE_LOW) && armed[0];
        flag_clear[1] = wr_take && (bus_addr == ior_pkg::OFF_COMPARE_VALUE_LOW) && armed[1];
        flag_clear[2] = rd_take && (bus_addr == ior_pkg::OFF_CAPTURE_VALUE_LOW) && armed[2];
    end

    always_comb begin
        next_tctl        = tctl;
        next_flags       = flags;
        next_armed       = armed;
        next_cnt_buf     = cnt_buf;
        next_cnt_latched = cnt_latched;
        next_cap_hold    = cap_hold;
        if (wr_take && bus_addr == ior_pkg::OFF_TIMER_CONTROL) begin
            next_tctl = bus_wdata & ior_pkg::TCTL_WRITE_MASK;
        end
        // Status read arms only flags seen set, so later events need a fresh read
        if (rd_take && bus_addr == ior_pkg::OFF_TIMER_STATUS) begin
            next_armed = flags;
        end
        next_armed = next_armed & ~flag_clear;
        // An event in the clearing cycle survives
        next_flags = (flags & ~flag_clear) | flag_event;
        // Low byte frozen by the first high read, released by the low read
        if (rd_take && (bus_addr == ior_pkg::OFF_COUNTER_VALUE_HIGH ||
                        bus_addr == ior_pkg::OFF_ALTERNATE_COUNTER_HIGH) && !cnt_latched) begin
            next_cnt_buf     = counter_value[7:0];
            next_cnt_latched = 1'b1;
        end
        if (rd_take && (bus_addr == ior_pkg::OFF_COUNTER_VALUE_LOW ||
                        bus_addr == ior_pkg::OFF_ALTERNATE_COUNTER_LOW)) begin
            next_cnt_latched = 1'b0;
        end
        if (rd_take && bus_addr == ior_pkg::OFF_CAPTURE_VALUE_HIGH) begin
            next_cap_hold = 1'b1;
        end
        if (rd_take && bus_addr == ior_pkg::OFF_CAPTURE_VALUE_LOW) begin
            next_cap_hold = 1'b0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tctl        <= ior_pkg::RST_TIMER_CONTROL;
            flags       <= ior_pkg::RST_TIMER_FLAGS;
            armed       <= 3'h0;
            cnt_buf     <= 8'h00;
            cnt_latched <= 1'b0;
            cap_hold    <= 1'b0;
        end else begin
            tctl        <= next_tctl;
            flags       <= next_flags;
            armed       <= next_armed;
            cnt_buf     <= next_cnt_buf;
            cnt_latched <= next_cnt_latched;
            cap_hold    <= next_cap_hold;
        end
    end

    // Compare word is storage the reset leaves alone, so it has no reset branch
    logic [15:0] cmp_q;
    logic [15:0] next_cmp;

    always_comb begin
        next_cmp = cmp_q;
        if (wr_take && bus_addr == ior_pkg::OFF_COMPARE_VALUE_HIGH) begin
            next_cmp[15:8] = bus_wdata;
        end
        if (wr_take && bus_addr == ior_pkg::OFF_COMPARE_VALUE_LOW) begin
            next_cmp[7:0] = bus_wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst) begin
            cmp_q <= next_cmp;
        end
    end

    // Read path
    logic [W-1:0] tsts;
    logic [W-1:0] cnt_low;
    logic [W-1:0] rd_mux;
    logic [W-1:0] next_rdata;
    logic         next_rvalid;

    always_comb begin
        tsts = 8'h00;
        tsts[ior_pkg::TSTS_CAPTURE_FLAG]  = flags[2];
        tsts[ior_pkg::TSTS_COMPARE_FLAG]  = flags[1];
        tsts[ior_pkg::TSTS_OVERFLOW_FLAG] = flags[0];
        cnt_low = cnt_latched ? cnt_buf : counter_value[7:0];
    end

    always_comb begin
        rd_mux = ior_pkg::RD_UNMAPPED;
        unique case (bus_addr)
            ior_pkg::OFF_FIRST_PORT_DATA,
            ior_pkg::OFF_SECOND_PORT_DATA,
            ior_pkg::OFF_THIRD_PORT_DATA,
            ior_pkg::OFF_FOURTH_PORT_DATA:       rd_mux = port_data_rd[bus_addr[1:0]];
            ior_pkg::OFF_FIRST_PORT_DIRECTION,
            ior_pkg::OFF_SECOND_PORT_DIRECTION,
            ior_pkg::OFF_THIRD_PORT_DIRECTION,
            ior_pkg::OFF_FOURTH_PORT_DIRECTION:  rd_mux = port_dir_rd[bus_addr[1:0]];
            ior_pkg::OFF_TIMER_CONTROL:          rd_mux = tctl;
            ior_pkg::OFF_TIMER_STATUS:           rd_mux = tsts;
            ior_pkg::OFF_CAPTURE_VALUE_HIGH:     rd_mux = capture_value[15:8];
            ior_pkg::OFF_CAPTURE_VALUE_LOW:      rd_mux = capture_value[7:0];
            ior_pkg::OFF_COMPARE_VALUE_HIGH:     rd_mux = cmp_q[15:8];
            ior_pkg::OFF_COMPARE_VALUE_LOW:      rd_mux = cmp_q[7:0];
            ior_pkg::OFF_COUNTER_VALUE_HIGH,
            ior_pkg::OFF_ALTERNATE_COUNTER_HIGH: rd_mux = counter_value[15:8];
            ior_pkg::OFF_COUNTER_VALUE_LOW,
            ior_pkg::OFF_ALTERNATE_COUNTER_LOW:  rd_mux = cnt_low;
            default:                             rd_mux = ior_pkg::RD_UNMAPPED;
        endcase
    end

    always_comb begin
        next_rvalid = rd_take;
        next_rdata  = rd_take ? rd_mux : bus_rdata;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            bus_rdata  <= 8'h00;
            bus_rvalid <= 1'b0;
        end else begin
            bus_rdata  <= next_rdata;
            bus_rvalid <= next_rvalid;
        end
    end

    // Timer-facing outputs
    assign capture_irq_enable   = tctl[ior_pkg::TCTL_CAPTURE_IRQ_ENABLE];
    assign compare_irq_enable   = tctl[ior_pkg::TCTL_COMPARE_IRQ_ENABLE];
    assign overflow_irq_enable  = tctl[ior_pkg::TCTL_OVERFLOW_IRQ_ENABLE];
    assign capture_edge_select  = tctl[ior_pkg::TCTL_CAPTURE_EDGE_SELECT];
    assign compare_output_level = tctl[ior_pkg::TCTL_COMPARE_OUTPUT_LEVEL];
    assign compare_value        = cmp_q;
    assign capture_inhibit      = cap_hold;
    assign timer_irq_request    = |(flags & {capture_irq_enable, compare_irq_enable, overflow_irq_enable});

endmodule : ior_io_regs

`default_nettype wire

// file: test/ior_io_regs_chk.sv
`timescale 1ns/1ps
`default_nettype none

module ior_io_regs_chk (
    // System
    input wire logic            clk,
    input wire logic            rst,
    // Memory bus
    input wire logic            bus_sel,
    input wire logic            bus_rd,
    input wire logic            bus_wr,
    input wire logic [4:0]      bus_addr,
    input wire logic [7:0]      bus_wdata,
    input wire logic [7:0]      bus_rdata,
    input wire logic            bus_rvalid,
    // Pins and timer controls
    input wire logic [3:0][7:0] port_pin_in,
    input wire logic [3:0][7:0] port_pin_out,
    input wire logic [3:0][7:0] port_pin_oe,
    input wire logic            capture_irq_enable,
    input wire logic            compare_irq_enable,
    input wire logic            overflow_irq_enable,
    input wire logic            capture_edge_select,
    input wire logic            compare_output_level
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    logic rd_t;
    logic wr_t;
    assign rd_t = bus_sel && bus_rd;
    assign wr_t = bus_sel && bus_wr;

    a_read_answer: assert property (rd_t |=> bus_rvalid)
        else $error("read not answered one cycle later");
    a_unmapped_zero: assert property ((rd_t && (bus_addr inside {[5'h08:5'h11], [5'h1C:5'h1F]})) |=>
        bus_rdata == 8'h00) else $error("unmapped offset read nonzero");
    a_second_data_bits: assert property ((rd_t && bus_addr == 5'h01) |=> bus_rdata[4:0] == 5'h00 &&
        bus_rdata[7:5] == ($past(port_pin_out[1][7:5]) | ($past(port_pin_in[1][7:5]) & ~$past(port_pin_oe[1][7:5]))))
        else $error("second port data read wrong");
    a_second_dir_ones: assert property ((rd_t && bus_addr == 5'h05) |=> bus_rdata[4:0] == 5'h1F)
        else $error("second port direction low bits not one");
    a_first_dir_pins: assert property ((wr_t && bus_addr == 5'h04) |=> port_pin_oe[0] == $past(bus_wdata))
        else $error("first port direction not on pin enables");
    a_fourth_data_bits: assert property ((rd_t && bus_addr == 5'h03) |=> (bus_rdata & 8'h5F) == 8'h10 &&
        bus_rdata[7] == $past(port_pin_in[3][7])) else $error("fourth port data read wrong");
    a_fourth_dir_bits: assert property ((rd_t && bus_addr == 5'h07) |=> (bus_rdata & 8'hDF) == 8'h00)
        else $error("fourth port direction stray bits");
    a_control_write: assert property ((wr_t && bus_addr == 5'h12) |=> {capture_irq_enable, compare_irq_enable,
        overflow_irq_enable, capture_edge_select, compare_output_level} == {$past(bus_wdata[7:5]), $past(bus_wdata[1:0])})
        else $error("timer control outputs differ from written value");
    a_status_low_zero: assert property ((rd_t && bus_addr == 5'h13) |=> bus_rdata[4:0] == 5'h00)
        else $error("status low bits nonzero");
    a_reset_quiet: assert property (disable iff (1'b0) rst |-> !bus_rvalid && port_pin_oe == '0)
        else $error("activity while reset held");
endmodule : ior_io_regs_chk

`default_nettype wire

// file: test/ior_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none

module ior_cpu_model (
    // System
    input  wire logic       clk,
    // Requests
    output var logic        bus_sel,
    output var logic        bus_rd,
    output var logic        bus_wr,
    output var logic [4:0]  bus_addr,
    output var logic [7:0]  bus_wdata,
    // Answer
    input  wire logic [7:0] bus_rdata,
    input  wire logic       bus_rvalid
);
    initial begin
        bus_sel = 1'b0;
        bus_rd = 1'b0;
        bus_wr = 1'b0;
        bus_addr = 5'h00;
        bus_wdata = 8'h00;
    end

    // Released lines show the inverse so stale values never match by luck
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        bus_sel <= 1'b1;
        bus_wr <= 1'b1;
        bus_addr <= a;
        bus_wdata <= d;
        @(posedge clk);
        bus_sel <= 1'b0;
        bus_wr <= 1'b0;
        bus_addr <= ~a;
        bus_wdata <= ~d;
        @(posedge clk);
    endtask : wr

    task automatic rd(input logic [4:0] a, output logic [7:0] d, output logic v);
        bus_sel <= 1'b1;
        bus_rd <= 1'b1;
        bus_addr <= a;
        @(posedge clk);
        bus_sel <= 1'b0;
        bus_rd <= 1'b0;
        bus_addr <= ~a;
        @(posedge clk);
        d = bus_rdata;
        v = bus_rvalid;
    endtask : rd
endmodule : ior_cpu_model

`default_nettype wire

// file: test/tb_ior_io_regs.sv
`timescale 1ns/1ps
`default_nettype none

module tb_ior_io_regs;
    logic clk = 1'b0;
    logic rst;
    logic bus_sel, bus_rd, bus_wr, bus_rvalid;
    logic [4:0] bus_addr;
    logic [7:0] bus_wdata, bus_rdata;
    logic [3:0][7:0] port_pin_in = '0;
    logic [3:0][7:0] port_pin_out, port_pin_oe;
    logic [15:0] counter_value = '0, capture_value = '0, compare_value;
    logic capture_event = 1'b0, compare_event = 1'b0, overflow_event = 1'b0;
    logic capture_irq_enable, compare_irq_enable, overflow_irq_enable, capture_edge_select;
    logic compare_output_level, capture_inhibit, timer_irq_request, capture_input_pin;
    int error_cnt = 0;
    int check_count = 0;
    int cyc = 0;
    // Expected state: latches, directions, control, compare, flags {capture, compare, overflow}
    logic [7:0] lat [4], dir [4], ctl, frz;
    logic [15:0] cmp;
    logic [2:0] flg, arm;
    logic frz_v, hold;

    always #50 clk = ~clk;

    ior_io_regs i_ior_io_regs (.clk, .rst, .bus_sel, .bus_rd, .bus_wr, .bus_addr, .bus_wdata, .bus_rdata,
        .bus_rvalid, .port_pin_in, .port_pin_out, .port_pin_oe, .counter_value, .capture_value, .capture_event,
        .compare_event, .overflow_event, .capture_irq_enable, .compare_irq_enable, .overflow_irq_enable,
        .capture_edge_select, .compare_output_level, .compare_value, .capture_inhibit, .timer_irq_request,
        .capture_input_pin);
    ior_cpu_model i_ior_cpu_model (.clk, .bus_sel, .bus_rd, .bus_wr, .bus_addr, .bus_wdata, .bus_rdata, .bus_rvalid);

    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : conclude

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            error_cnt++;
            conclude();
        end
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : check

    function automatic logic [7:0] exp_rd(input logic [4:0] a);
        int p;
        p = a[1:0];
        if (a < 5'h04) return (((lat[p] & dir[p]) | (port_pin_in[p] & ~dir[p])) & ior_pkg::PORT_BIDIR_MASK[p])
            | (port_pin_in[p] & ior_pkg::PORT_INPUT_MASK[p]) | ior_pkg::PORT_DATA_ONE_MASK[p];
        if (a < 5'h08) return dir[p] | ior_pkg::PORT_DIR_ONE_MASK[p];
        case (a)
            5'h12: return ctl;
            5'h13: return {flg, 5'h00};
            5'h14: return capture_value[15:8];
            5'h15: return capture_value[7:0];
            5'h16: return cmp[15:8];
            5'h17: return cmp[7:0];
            5'h18, 5'h1A: return counter_value[15:8];
            5'h19, 5'h1B: return frz_v ? frz : counter_value[7:0];
            default: return 8'h00;
        endcase
    endfunction : exp_rd

    task automatic rd_chk(input logic [4:0] a);
        logic [7:0] d;
        logic v;
        i_ior_cpu_model.rd(a, d, v);
        check(v, 1'b1, "read strobe");
        check(d, exp_rd(a), $sformatf("read offset %h", a));
        if (a == 5'h13) arm = flg;
        if (a == 5'h18 || a == 5'h1A) begin
            if (!frz_v) frz = counter_value[7:0];
            frz_v = 1'b1;
        end
        if (a == 5'h19 || a == 5'h1B) frz_v = 1'b0;
        if (a == 5'h14 || a == 5'h15) hold = (a == 5'h14);
        if (a == 5'h15) begin
            flg[2] = flg[2] & ~arm[2];
            arm[2] = 1'b0;
        end
        if (a == 5'h19) begin
            flg[0] = flg[0] & ~arm[0];
            arm[0] = 1'b0;
        end
    endtask : rd_chk

    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        i_ior_cpu_model.wr(a, d);
        if (a < 5'h04) lat[a[1:0]] = d;
        else if (a < 5'h08) dir[a[1:0]] = d & ior_pkg::PORT_BIDIR_MASK[a[1:0]];
        else if (a == 5'h12) ctl = d & ior_pkg::TCTL_WRITE_MASK;
        else if (a == 5'h16) cmp[15:8] = d;
        else if (a == 5'h17) begin
            cmp[7:0] = d;
            flg[1] = flg[1] & ~arm[1];
            arm[1] = 1'b0;
        end
    endtask : wr

    task automatic pins_chk();
        for (int p = 0; p < 4; p++) begin
            check(port_pin_oe[p] & ior_pkg::PORT_BIDIR_MASK[p], dir[p], "pin enable");
            check(port_pin_out[p] & ior_pkg::PORT_BIDIR_MASK[p], lat[p] & dir[p], "pin drive");
        end
        check({capture_irq_enable, compare_irq_enable, overflow_irq_enable, capture_edge_select,
            compare_output_level}, {ctl[7:5], ctl[1:0]}, "control outputs");
        check(timer_irq_request, |(flg & ctl[7:5]), "timer request");
        check(capture_input_pin, port_pin_in[3][7], "capture pin");
        check(compare_value, cmp, "compare word");
        check(capture_inhibit, hold, "capture hold");
    endtask : pins_chk

    // Compare register is deliberately kept, it survives reset
    task automatic model_reset();
        for (int p = 0; p < 4; p++) begin
            lat[p] = 8'h00;
            dir[p] = 8'h00;
        end
        ctl = 8'h00;
        flg = 3'h0;
        arm = 3'h0;
        frz_v = 1'b0;
        hold = 1'b0;
    endtask : model_reset

    task automatic sweep();
        for (int a = 0; a < 32; a++) rd_chk(5'(a));
        pins_chk();
    endtask : sweep

    initial begin
        // Edge on reset at time zero so outputs are defined before the first clock
        rst <= 1'b1;
        void'($urandom(91497));
        model_reset();
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        wr(5'h16, 8'h5A);
        wr(5'h17, 8'hC3);
        sweep();
        $display("test reset values done");
        repeat (300) begin
            port_pin_in <= $urandom;
            counter_value <= 16'($urandom);
            capture_value <= 16'($urandom);
            if ($urandom % 2) wr(5'($urandom), 8'($urandom));
            else rd_chk(5'($urandom));
            pins_chk();
        end
        $display("test random access done");
        wr(5'h12, 8'hE0);
        for (int k = 0; k < 3; k++) begin
            {capture_event, compare_event, overflow_event} <= 3'b100 >> k;
            @(posedge clk);
            {capture_event, compare_event, overflow_event} <= 3'b000;
            // Flag lands at the event edge, so look one edge later
            @(posedge clk);
            flg = flg | (3'b100 >> k);
            pins_chk();
            rd_chk(5'h19);
            rd_chk(5'h13);
            rd_chk(5'h1A);
            rd_chk(5'h1B);
            rd_chk(5'h13);
            if (k == 0) begin
                rd_chk(5'h14);
                rd_chk(5'h15);
            end else if (k == 1) wr(5'h17, 8'h3C);
            else begin
                rd_chk(5'h18);
                rd_chk(5'h19);
            end
            rd_chk(5'h13);
            pins_chk();
        end
        $display("test flag clearing done");
        rd_chk(5'h19);
        rst <= 1'b1;
        i_ior_cpu_model.wr(5'h16, 8'hFF);
        rst <= 1'b0;
        model_reset();
        @(posedge clk);
        sweep();
        $display("test retention done");
        conclude();
    end
endmodule : tb_ior_io_regs

bind ior_io_regs ior_io_regs_chk i_ior_io_regs_chk (.clk, .rst, .bus_sel, .bus_rd, .bus_wr, .bus_addr, .bus_wdata,
    .bus_rdata, .bus_rvalid, .port_pin_in, .port_pin_out, .port_pin_oe, .capture_irq_enable, .compare_irq_enable,
    .overflow_irq_enable, .capture_edge_select, .compare_output_level);

`default_nettype wire
